// ===== hdl/internal_clock_generator.sv
// internal clock generator: mode control, dividers, source mux and register port
// assumes all clocks arrive as one-cycle tick pulses on clk and no port reaches a pad
//
// Functional notes
// - reset starts in loop engaged internal mode
// - selected source passes 1/2/4/8 bus divider
// - bus clock is half generator output
// - debug clock is loop oscillator divided two
// - loop reference passes three-bit reference divider
// - nine-bit trim value adjusts internal reference
// - external reference up to 5 MHz accepted
// - engaged internal: output and debug from loop
// - engaged external: output and debug from loop
// - bypass internal: loop runs, output internal
// - bypass internal low power: loop off
// - bypass external: loop runs, output external
// - bypass external low power: loop off
// - stop: no clocks, references per keep bits
// - drive low-power oscillator control outputs
// - all signals stay internal to chip
// - bus divider codes, reset to divide two
// - reference divider power of two, reset one
// - low power disables loop in bypass modes unless debugging
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module internal_clock_generator (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// register port
	input  wire logic [1:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	// clock source ticks
	input  wire logic       intRefTick,
	input  wire logic       extRefTick,
	input  wire logic       loopOscTick,
	// system state
	input  wire logic       stopReq,
	input  wire logic       debugActive,
	// generated clocks
	output logic            genOutTick,
	output logic            busClkTick,
	output logic            debugClkTick,
	output logic            loopRefTick,
	// loop and reference control
	output logic            loopEnable,
	output logic            intRefEnable,
	output logic            extRefEnable,
	output logic      [8:0] trimValue,
	// oscillator control
	output logic            oscHighGain,
	output logic            oscHighRange,
	output logic            oscSelect,
	output logic            oscEnable,
	output logic            oscStopKeep
);

	logic [7:0]             ctrl1_reg, ctrl1_next;
	logic [7:0]             ctrl2_reg, ctrl2_next;
	logic [7:0]             trim_reg, trim_next;
	logic                   fine_reg, fine_next;
	logic [7:0]             rd_reg, rd_next;
	clock_gen_pkg::src_t    src_reg, src_next;
	logic                   loopEn_reg, loopEn_next;
	logic                   intEn_reg, intEn_next;
	logic                   extEn_reg, extEn_next;
	logic [8:0]             trimOut_reg, trimOut_next;
	logic [4:0]             osc_reg, osc_next;
	clock_gen_pkg::mode_t   modeNow;
	clock_gen_pkg::mode_t   modeRun;
	clock_gen_pkg::src_t    srcWant;
	logic [1:0]             clkSel;
	logic [1:0]             busDivSel;
	logic [2:0]             refDivSel;
	logic                   loopOn;
	logic                   srcTick;
	logic                   srcSwitch;
	logic                   refTickIn;
	logic                   intUsed;
	logic                   extUsed;
	logic [1:0]             wrClkSel;

	assign clkSel    = ctrl1_reg[clock_gen_pkg::CLKS_LSB +: clock_gen_pkg::CLKS_W];
	assign refDivSel = ctrl1_reg[clock_gen_pkg::REF_DIVIDER_SELECT_LSB +: clock_gen_pkg::REF_DIVIDER_SELECT_W];
	assign busDivSel = ctrl2_reg[clock_gen_pkg::BUS_DIVIDER_SELECT_LSB +: clock_gen_pkg::BUS_DIVIDER_SELECT_W];

	clock_mode_decode modeStop (
		.clkSel      (clkSel),
		.intRefSel   (ctrl1_reg[clock_gen_pkg::IREF_SEL_BIT]),
		.lowPower    (ctrl2_reg[clock_gen_pkg::LP_BIT]),
		.debugActive (debugActive),
		.stopReq     (stopReq),
		.mode        (modeNow)
	);

	clock_mode_decode modeFree (
		.clkSel      (clkSel),
		.intRefSel   (ctrl1_reg[clock_gen_pkg::IREF_SEL_BIT]),
		.lowPower    (ctrl2_reg[clock_gen_pkg::LP_BIT]),
		.debugActive (debugActive),
		.stopReq     (1'b0),
		.mode        (modeRun)
	);

	always_comb
	begin
		// loop state and source per mode
		loopOn  = 1'b1;
		srcWant = clock_gen_pkg::SRC_LOOP;
		unique case (modeNow)
			clock_gen_pkg::MODE_FEI,
			clock_gen_pkg::MODE_FEE:   srcWant = clock_gen_pkg::SRC_LOOP;
			clock_gen_pkg::MODE_FBI:   srcWant = clock_gen_pkg::SRC_INT;
			clock_gen_pkg::MODE_FBE:   srcWant = clock_gen_pkg::SRC_EXT;
			clock_gen_pkg::MODE_LOOP_BYPASS_INT_REF_LOWPWR:
			begin
				srcWant = clock_gen_pkg::SRC_INT;
				loopOn  = 1'b0;
			end
			clock_gen_pkg::MODE_LOOP_BYPASS_EXT_REF_LOWPWR:
			begin
				srcWant = clock_gen_pkg::SRC_EXT;
				loopOn  = 1'b0;
			end
			clock_gen_pkg::MODE_STOP:
			begin
				srcWant = clock_gen_pkg::SRC_NONE;
				loopOn  = 1'b0;
			end
		endcase
		// loop reference from internal or external tick
		refTickIn = (ctrl1_reg[clock_gen_pkg::IREF_SEL_BIT] ? intRefTick : extRefTick)
			&& loopOn;
		unique case (src_reg)
			clock_gen_pkg::SRC_NONE: srcTick = 1'b0;
			clock_gen_pkg::SRC_LOOP: srcTick = loopOscTick;
			clock_gen_pkg::SRC_INT:  srcTick = intRefTick;
			clock_gen_pkg::SRC_EXT:  srcTick = extRefTick;
		endcase
		// switch only between ticks of the old source
		srcSwitch = (srcWant != src_reg) && !srcTick;
		src_next  = srcSwitch ? srcWant : src_reg;
		// references in stop follow keep bits
		intUsed = ctrl1_reg[clock_gen_pkg::IREF_EN_BIT] || modeRun == clock_gen_pkg::MODE_FEI
			|| modeRun == clock_gen_pkg::MODE_FBI || modeRun == clock_gen_pkg::MODE_LOOP_BYPASS_INT_REF_LOWPWR;
		extUsed = ctrl2_reg[clock_gen_pkg::EXT_EN_BIT] || modeRun == clock_gen_pkg::MODE_FEE
			|| modeRun == clock_gen_pkg::MODE_FBE || modeRun == clock_gen_pkg::MODE_LOOP_BYPASS_EXT_REF_LOWPWR;
		intEn_next = intUsed && (!stopReq || ctrl1_reg[clock_gen_pkg::IREF_STP_BIT]);
		extEn_next = extUsed && (!stopReq || ctrl2_reg[clock_gen_pkg::EXT_STP_BIT]);
		loopEn_next = loopOn;
		// trim from byte and fine bit
		trimOut_next = {trim_reg, fine_reg};
		osc_next = {ctrl2_reg[clock_gen_pkg::HGO_BIT], ctrl2_reg[clock_gen_pkg::RANGE_BIT],
			ctrl2_reg[clock_gen_pkg::EXT_SRC_BIT], extEn_next,
			ctrl2_reg[clock_gen_pkg::EXT_STP_BIT]};
	end

	tick_pow2_divider #(.SEL_W(2)) busDivider (
		.clk     (clk),
		.rst_n   (rst_n),
		.clear   (srcSwitch),
		.divSel  (busDivSel),
		.tickIn  (srcTick),
		.tickOut (genOutTick)
	);

	tick_pow2_divider #(.SEL_W(1)) busHalver (
		.clk     (clk),
		.rst_n   (rst_n),
		.clear   (1'b0),
		.divSel  (clock_gen_pkg::DIV2_SEL),
		.tickIn  (genOutTick),
		.tickOut (busClkTick)
	);

	tick_pow2_divider #(.SEL_W(1)) debugDivider (
		.clk     (clk),
		.rst_n   (rst_n),
		.clear   (!loopOn),
		.divSel  (clock_gen_pkg::DIV2_SEL),
		.tickIn  (loopOscTick && loopOn),
		.tickOut (debugClkTick)
	);

	tick_pow2_divider #(.SEL_W(3)) refDivider (
		.clk     (clk),
		.rst_n   (rst_n),
		.clear   (!loopOn),
		.divSel  (refDivSel),
		.tickIn  (refTickIn),
		.tickOut (loopRefTick)
	);

	always_comb
	begin
		ctrl1_next = ctrl1_reg;
		ctrl2_next = ctrl2_reg;
		trim_next  = trim_reg;
		fine_next  = fine_reg;
		rd_next    = clock_gen_pkg::READ_ZERO;
		wrClkSel   = regWrData[clock_gen_pkg::CLKS_LSB +: clock_gen_pkg::CLKS_W];
		if (regWrite)
		begin
			unique case (regAddr)
				clock_gen_pkg::REG_CTRL1:
				begin
					ctrl1_next = regWrData;
					// reserved source code falls back to loop
					if (wrClkSel == clock_gen_pkg::CLKS_RSVD)
						ctrl1_next[clock_gen_pkg::CLKS_LSB +: clock_gen_pkg::CLKS_W] =
							clock_gen_pkg::CLKS_LOOP;
				end
				clock_gen_pkg::REG_CTRL2:  ctrl2_next = regWrData;
				clock_gen_pkg::REG_TRIM:   trim_next  = regWrData;
				clock_gen_pkg::REG_STATUS: fine_next  = regWrData[clock_gen_pkg::FINE_BIT];
			endcase
		end
		if (regRead)
		begin
			unique case (regAddr)
				clock_gen_pkg::REG_CTRL1:  rd_next = ctrl1_reg;
				clock_gen_pkg::REG_CTRL2:  rd_next = ctrl2_reg;
				clock_gen_pkg::REG_TRIM:   rd_next = trim_reg;
				clock_gen_pkg::REG_STATUS:
				begin
					rd_next[clock_gen_pkg::FINE_BIT]    = fine_reg;
					rd_next[clock_gen_pkg::MODE_LSB +: clock_gen_pkg::MODE_W] = modeNow;
					rd_next[clock_gen_pkg::LOOP_ON_BIT] = loopEn_reg;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl1_reg   <= clock_gen_pkg::CTRL1_RESET;
			ctrl2_reg   <= clock_gen_pkg::CTRL2_RESET;
			trim_reg    <= clock_gen_pkg::TRIM_RESET;
			fine_reg    <= clock_gen_pkg::FINE_RESET;
			rd_reg      <= clock_gen_pkg::READ_ZERO;
			src_reg     <= clock_gen_pkg::SRC_LOOP;
			loopEn_reg  <= 1'b1;
			intEn_reg   <= 1'b1;
			extEn_reg   <= 1'b0;
			trimOut_reg <= {clock_gen_pkg::TRIM_RESET, clock_gen_pkg::FINE_RESET};
			osc_reg     <= '0;
		end
		else
		begin
			ctrl1_reg   <= ctrl1_next;
			ctrl2_reg   <= ctrl2_next;
			trim_reg    <= trim_next;
			fine_reg    <= fine_next;
			rd_reg      <= rd_next;
			src_reg     <= src_next;
			loopEn_reg  <= loopEn_next;
			intEn_reg   <= intEn_next;
			extEn_reg   <= extEn_next;
			trimOut_reg <= trimOut_next;
			osc_reg     <= osc_next;
		end
	end

	// outputs go only to on-chip consumers
	assign regRdData    = rd_reg;
	assign loopEnable   = loopEn_reg;
	assign intRefEnable = intEn_reg;
	assign extRefEnable = extEn_reg;
	assign trimValue    = trimOut_reg;
	assign oscHighGain  = osc_reg[4];
	assign oscHighRange = osc_reg[3];
	assign oscSelect    = osc_reg[2];
	assign oscEnable    = osc_reg[1];
	assign oscStopKeep  = osc_reg[0];

	sequence sStopHeld;
		stopReq ##1 stopReq;
	endsequence

	sequence sDiv1Steady;
		busDivSel == 2'h0 && !srcSwitch ##1 busDivSel == 2'h0;
	endsequence

	AST_FEI_DEFAULT: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl1_reg == clock_gen_pkg::CTRL1_RESET && !stopReq) |->
		modeNow == clock_gen_pkg::MODE_FEI && srcWant == clock_gen_pkg::SRC_LOOP)
		else $error("reset configuration not engaged internal");
	AST_DIV1_PASS: assert property (@(posedge clk) disable iff (!rst_n)
		sDiv1Steady |-> genOutTick == $past(srcTick))
		else $error("divide by one does not pass source ticks");
	AST_BUS_HALF: assert property (@(posedge clk) disable iff (!rst_n)
		busClkTick |-> $past(genOutTick) && !genOutTick ##1 !busClkTick)
		else $error("bus clock not half of generator output");
	AST_DEBUG_LOOP: assert property (@(posedge clk) disable iff (!rst_n)
		debugClkTick |-> $past(loopOscTick) && $past(loopOn))
		else $error("debug tick without loop tick");
	AST_REF_GATED: assert property (@(posedge clk) disable iff (!rst_n)
		loopRefTick |-> $past(refTickIn))
		else $error("loop reference tick without input tick");
	AST_LOWPWR_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		(modeNow == clock_gen_pkg::MODE_LOOP_BYPASS_INT_REF_LOWPWR || modeNow == clock_gen_pkg::MODE_LOOP_BYPASS_EXT_REF_LOWPWR)
		|=> !loopEnable)
		else $error("loop enabled in low power bypass");
	AST_STOP_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		sStopHeld |-> !debugClkTick && !loopEnable && !loopRefTick)
		else $error("clock activity during stop");
	AST_BYPASS_ON: assert property (@(posedge clk) disable iff (!rst_n)
		(clkSel != clock_gen_pkg::CLKS_LOOP && !stopReq
		&& (!ctrl2_reg[clock_gen_pkg::LP_BIT] || debugActive)) |=> loopEnable)
		else $error("loop disabled while low power inactive");
	AST_TRIM_OUT: assert property (@(posedge clk) disable iff (!rst_n)
		regWrite && regAddr == clock_gen_pkg::REG_TRIM |=> ##1 trimValue[8:1] == $past(regWrData, 2))
		else $error("trim value not applied");

endmodule : internal_clock_generator

// ===== hdl/clock_gen_pkg.sv
// constants for the internal clock generator: register map, fields, resets, modes
// assumes an 8-bit register port with a 2-bit word index
package clock_gen_pkg;

	// register indices
	localparam logic [1:0] REG_CTRL1  = 2'h0;
	localparam logic [1:0] REG_CTRL2  = 2'h1;
	localparam logic [1:0] REG_TRIM   = 2'h2;
	localparam logic [1:0] REG_STATUS = 2'h3;

	// control 1 fields
	localparam int CLKS_LSB     = 6;
	localparam int CLKS_W       = 2;
	localparam int REF_DIVIDER_SELECT_LSB     = 3;
	localparam int REF_DIVIDER_SELECT_W       = 3;
	localparam int IREF_SEL_BIT = 2;
	localparam int IREF_EN_BIT  = 1;
	localparam int IREF_STP_BIT = 0;

	// control 2 fields
	localparam int BUS_DIVIDER_SELECT_LSB     = 6;
	localparam int BUS_DIVIDER_SELECT_W       = 2;
	localparam int RANGE_BIT    = 5;
	localparam int HGO_BIT      = 4;
	localparam int LP_BIT       = 3;
	localparam int EXT_SRC_BIT  = 2;
	localparam int EXT_EN_BIT   = 1;
	localparam int EXT_STP_BIT  = 0;

	// status fields
	localparam int FINE_BIT     = 0;
	localparam int MODE_LSB     = 2;
	localparam int MODE_W       = 3;
	localparam int LOOP_ON_BIT  = 5;

	// clock source select codes
	localparam logic [1:0] CLKS_LOOP  = 2'h0;
	localparam logic [1:0] CLKS_INT   = 2'h1;
	localparam logic [1:0] CLKS_EXT   = 2'h2;
	localparam logic [1:0] CLKS_RSVD  = 2'h3;

	// reset values
	localparam logic [7:0] CTRL1_RESET = 8'h04;
	localparam logic [7:0] CTRL2_RESET = 8'h40;
	localparam logic [7:0] TRIM_RESET  = 8'h80;
	localparam logic       FINE_RESET  = 1'h0;
	localparam logic [7:0] READ_ZERO   = 8'h00;

	// fixed divide-by-two selects
	localparam logic       DIV2_SEL    = 1'h1;

	typedef enum logic [2:0] {
		MODE_FEI,
		MODE_FEE,
		MODE_FBI,
		MODE_LOOP_BYPASS_INT_REF_LOWPWR,
		MODE_FBE,
		MODE_LOOP_BYPASS_EXT_REF_LOWPWR,
		MODE_STOP
	} mode_t;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_LOOP,
		SRC_INT,
		SRC_EXT
	} src_t;

endpackage : clock_gen_pkg

// ===== hdl/tick_pow2_divider.sv
// divides a tick stream by two raised to a select value
// assumes input ticks are one-cycle enable pulses on clk
`timescale 1ns/1ps
module tick_pow2_divider #(
	parameter int SEL_W = 2
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// control
	input  wire logic             clear,
	input  wire logic [SEL_W-1:0] divSel,
	// ticks
	input  wire logic             tickIn,
	output logic                  tickOut
);

	localparam int CNT_W = (1 << SEL_W) - 1;

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic             tick_reg;
	logic             tick_next;

	function automatic logic [CNT_W-1:0] countLimit(input logic [SEL_W-1:0] sel);
		logic [CNT_W:0] full;
		full = {{CNT_W{1'b0}}, 1'b1} << sel;
		countLimit = CNT_W'(full - 1'b1);
	endfunction : countLimit

	always_comb
	begin
		count_next = count_reg;
		tick_next  = 1'b0;
		if (clear)
			count_next = '0;
		else if (tickIn)
		begin
			if (count_reg >= countLimit(divSel))
			begin
				count_next = '0;
				tick_next  = 1'b1;
			end
			else
				count_next = count_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_reg <= '0;
			tick_reg  <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			tick_reg  <= tick_next;
		end
	end

	assign tickOut = tick_reg;

endmodule : tick_pow2_divider

// ===== hdl/clock_mode_decode.sv
// decodes the operating mode from source select, reference select and power setting
// assumes all inputs are registered control bits or synchronous levels
`timescale 1ns/1ps
module clock_mode_decode (
	// configuration
	input  wire logic [1:0]           clkSel,
	input  wire logic                 intRefSel,
	input  wire logic                 lowPower,
	// system state
	input  wire logic                 debugActive,
	input  wire logic                 stopReq,
	// decoded mode
	output clock_gen_pkg::mode_t      mode
);

	logic powerDown;

	always_comb
	begin
		powerDown = lowPower && !debugActive;
		mode      = intRefSel ? clock_gen_pkg::MODE_FEI : clock_gen_pkg::MODE_FEE;
		if (stopReq)
			mode = clock_gen_pkg::MODE_STOP;
		else if (clkSel == clock_gen_pkg::CLKS_INT)
			mode = powerDown ? clock_gen_pkg::MODE_LOOP_BYPASS_INT_REF_LOWPWR : clock_gen_pkg::MODE_FBI;
		else if (clkSel == clock_gen_pkg::CLKS_EXT)
			mode = powerDown ? clock_gen_pkg::MODE_LOOP_BYPASS_EXT_REF_LOWPWR : clock_gen_pkg::MODE_FBE;
	end

endmodule : clock_mode_decode

// ===== test/tick_source_model.sv
// clock sources seen by the generator: loop oscillator, internal and external references
// assumes one clk domain; each source gives one-cycle ticks, never back to back
`timescale 1ns/1ps
module tick_source_model #(
	parameter int LOOP_P = 3,
	parameter int INT_P  = 5,
	parameter int EXT_P  = 7
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// source enables
	input  wire logic loopEnable,
	input  wire logic intRefEnable,
	input  wire logic extRefEnable,
	// ticks
	output logic      loopOscTick,
	output logic      intRefTick,
	output logic      extRefTick
);
	int loopCnt;
	int intCnt;
	int extCnt;

	// a source that is switched off gives no ticks
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loopCnt <= 0;
			intCnt <= 0;
			extCnt <= 0;
			loopOscTick <= 1'b0;
			intRefTick <= 1'b0;
			extRefTick <= 1'b0;
		end
		else
		begin
			loopCnt <= (loopCnt + 1) % LOOP_P;
			intCnt <= (intCnt + 1) % INT_P;
			extCnt <= (extCnt + 1) % EXT_P;
			loopOscTick <= loopEnable && (loopCnt == 0);
			intRefTick <= intRefEnable && (intCnt == 0);
			extRefTick <= extRefEnable && (extCnt == 0);
		end
	end
endmodule : tick_source_model

// ===== test/tb.sv
// testbench for the internal clock generator
// assumes the tick source model on the source side and a plain register port
`timescale 1ns/1ps
module tb;
	logic       clk, rst_n, regWrite, regRead, stopReq, debugActive;
	logic [1:0] regAddr;
	logic [7:0] regWrData, d;
	wire  [7:0] regRdData;
	wire  [8:0] trimValue;
	wire        intRefTick, extRefTick, loopOscTick, genOutTick, busClkTick, debugClkTick;
	wire        loopRefTick, loopEnable, intRefEnable, extRefEnable;
	wire        oscHighGain, oscHighRange, oscSelect, oscEnable, oscStopKeep;
	int         errCount, checked, cycles, nLoop, nInt, nExt, nGen, nBus, nDbg, nRef, e;
	logic       counting;
	logic [7:0] mC1 [8] = '{8'h06, 8'h02, 8'h46, 8'h46, 8'h82, 8'h82, 8'h46, 8'h06};
	logic [7:0] mC2 [8] = '{8'h02, 8'h02, 8'h02, 8'h0A, 8'h02, 8'h0A, 8'h0A, 8'h02};
	logic       mStp[8] = '{0, 0, 0, 0, 0, 0, 0, 1};
	logic       mDbg[8] = '{0, 0, 0, 0, 0, 0, 1, 0};
	logic       mLp [8] = '{1, 1, 1, 0, 1, 0, 1, 0};
	logic [2:0] mMd [8] = '{0, 1, 2, 3, 4, 5, 2, 6};
	int         mSrc[8] = '{0, 0, 1, 1, 2, 2, 1, 3};

	internal_clock_generator internal_clock_generator_inst (.clk(clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .intRefTick(intRefTick), .extRefTick(extRefTick),
		.loopOscTick(loopOscTick), .stopReq(stopReq), .debugActive(debugActive),
		.genOutTick(genOutTick), .busClkTick(busClkTick), .debugClkTick(debugClkTick),
		.loopRefTick(loopRefTick), .loopEnable(loopEnable), .intRefEnable(intRefEnable),
		.extRefEnable(extRefEnable), .trimValue(trimValue), .oscHighGain(oscHighGain),
		.oscHighRange(oscHighRange), .oscSelect(oscSelect), .oscEnable(oscEnable),
		.oscStopKeep(oscStopKeep));
	tick_source_model tick_source_model_inst (.clk(clk), .rst_n(rst_n),
		.loopEnable(loopEnable), .intRefEnable(intRefEnable), .extRefEnable(extRefEnable),
		.loopOscTick(loopOscTick), .intRefTick(intRefTick), .extRefTick(extRefTick));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (counting)
		begin
			nLoop += loopOscTick;
			nInt += intRefTick;
			nExt += extRefTick;
			nGen += genOutTick;
			nBus += busClkTick;
			nDbg += debugClkTick;
			nRef += loopRefTick;
		end
		cycles++;
		if (cycles == 30000)
		begin
			errCount++;
			results();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errCount++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task near(input int seen, input int exp);
		check({31'h0, (seen <= exp + 2) && (seen + 2 >= exp)}, 32'h1);
	endtask : near

	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr

	task rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 v = regRdData;
	endtask : rd

	task cfg(input logic [7:0] c1, input logic [7:0] c2, input logic s, input logic g);
		wr(clock_gen_pkg::REG_CTRL1, c1);
		wr(clock_gen_pkg::REG_CTRL2, c2);
		stopReq <= s;
		debugActive <= g;
		repeat (40) @(posedge clk);
	endtask : cfg

	task window();
		@(posedge clk);
		#1 {nLoop, nInt, nExt, nGen, nBus, nDbg, nRef} = '0;
		counting = 1'b1;
		repeat (600) @(posedge clk);
		#1 counting = 1'b0;
	endtask : window

	task testReset();
		check({loopEnable, intRefEnable, extRefEnable, trimValue}, {3'b110, 9'h100});
		check({oscHighGain, oscHighRange, oscSelect, oscEnable, oscStopKeep}, 5'h0);
		rd(clock_gen_pkg::REG_CTRL1, d);
		check(d, 8'h04);
		rd(clock_gen_pkg::REG_CTRL2, d);
		check(d, 8'h40);
		rd(clock_gen_pkg::REG_STATUS, d);
		check(d, 8'h20);
		@(posedge clk) #1 check(regRdData, 8'h00);
	endtask : testReset

	task testRegs();
		wr(clock_gen_pkg::REG_CTRL1, 8'hFF);
		rd(clock_gen_pkg::REG_CTRL1, d);
		check(d, 8'h3F);
		wr(clock_gen_pkg::REG_CTRL2, 8'hA5);
		rd(clock_gen_pkg::REG_CTRL2, d);
		check(d, 8'hA5);
		wr(clock_gen_pkg::REG_TRIM, 8'h5A);
		wr(clock_gen_pkg::REG_STATUS, 8'hFF);
		rd(clock_gen_pkg::REG_TRIM, d);
		check(d, 8'h5A);
		check(trimValue, 9'h0B5);
		wr(clock_gen_pkg::REG_STATUS, 8'h00);
		@(posedge clk) #1 check(trimValue, 9'h0B4);
	endtask : testRegs

	task testOsc(input logic [7:0] c);
		wr(clock_gen_pkg::REG_CTRL2, c);
		@(posedge clk) #1;
		check({oscHighRange, oscHighGain, oscSelect, oscEnable, oscStopKeep}, {c[5:4], c[2:0]});
	endtask : testOsc

	task testModes();
		for (int i = 0; i < 8; i++)
		begin
			cfg(mC1[i], mC2[i], mStp[i], mDbg[i]);
			window();
			e = (mSrc[i] == 0) ? nLoop : (mSrc[i] == 1) ? nInt : (mSrc[i] == 2) ? nExt : 0;
			near(nGen, e);
			near(nBus, nGen / 2);
			near(nDbg, nLoop / 2);
			check(loopEnable, mLp[i]);
			if (mStp[i]) check(nRef, 0);
			rd(clock_gen_pkg::REG_STATUS, d);
			check(d, {2'b00, mLp[i], mMd[i], 2'b00});
		end
	endtask : testModes

	task testBusDiv();
		for (int k = 0; k < 4; k++)
		begin
			cfg(8'h06, {k[1:0], 6'h02}, 1'b0, 1'b0);
			window();
			near(nGen, nLoop >> k);
			near(nBus, nGen / 2);
			near(nDbg, nLoop / 2);
		end
	endtask : testBusDiv

	task testRefDiv(input logic [2:0] r, input logic ir);
		cfg({2'b00, r, ir, 2'b10}, 8'h02, 1'b0, 1'b0);
		window();
		near(nRef, (ir ? nInt : nExt) >> r);
	endtask : testRefDiv

	task testStopKeep(input logic [7:0] c1, input logic [7:0] c2, input logic on);
		cfg(c1, c2, 1'b1, 1'b0);
		#1 check({intRefEnable, extRefEnable, loopEnable}, {on, on, 1'b0});
		@(posedge clk);
		stopReq <= 1'b0;
	endtask : testStopKeep

	task testMidReset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk) #1;
		testReset();
	endtask : testMidReset

	task results();
		$display("mismatches %0d of %0d comparisons", errCount, checked);
		if (errCount == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	initial
	begin
		{rst_n, regWrite, regRead, stopReq, debugActive, counting} = '0;
		regAddr = 2'h0;
		regWrData = 8'h00;
		{errCount, checked, cycles} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk) #1;
		testReset();
		testRegs();
		testOsc(8'h37);
		testOsc(8'h00);
		testModes();
		testBusDiv();
		testRefDiv(3'h0, 1'b1);
		testRefDiv(3'h3, 1'b1);
		testRefDiv(3'h7, 1'b1);
		testRefDiv(3'h1, 1'b0);
		// regulator assumed on while internal reference kept
		testStopKeep(8'h07, 8'h03, 1'b1);
		testStopKeep(8'h06, 8'h02, 1'b0);
		testMidReset();
		results();
	end
endmodule : tb
